// ### msk_modem_pkg.sv
// Purpose: Shared constants for the MSK modem control link, both ends
// Assumes: 20 MHz system clock on both ends
// Notes: Serial word is A1 A0 D7..D0, sent MSB first
package msk_modem_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 50;
	localparam int SCLK_HALF_NS = 500;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int TX_BIT_HZ = 2400;
	localparam int TX_HALF_CYC = CLK_HZ / (2 * TX_BIT_HZ);
	localparam int RX_BIT_CYC = CLK_HZ / TX_BIT_HZ;
	localparam int VOICE_GUARD_MS = 2;
	localparam int VOICE_GUARD_CYC = VOICE_GUARD_MS * (CLK_HZ / 1000);
	localparam int WR_BITS = 10;
	localparam int RD_BITS = 8;
	localparam int SYNC_BITS = 16;

	localparam logic [1:0] ADDR_CTRL1 = 2'h0;
	localparam logic [1:0] ADDR_VOL_RX = 2'h1;
	localparam logic [1:0] ADDR_VOL_TX = 2'h2;
	localparam logic [1:0] ADDR_CTRL2 = 2'h3;
	localparam logic [7:0] CTRL1_RST = 8'hCC;
	localparam logic [7:0] VOL_RX_RST = 8'hF4;
	localparam logic [7:0] VOL_TX_RST = 8'h88;
	localparam logic [7:0] CTRL2_RST = 8'hD8;
	localparam logic [3:0] VOL_RX_FIXED = 4'hF;

	localparam int C1_FLAG_SEL = 7;
	localparam int C1_PWR_HI = 6;
	localparam int C1_PWR_LO = 5;
	localparam int C1_HUNT = 4;
	localparam int C1_SCR_BYP = 3;
	localparam int C1_TX_DIS = 2;
	localparam int C1_TX_MUTE = 1;
	localparam int C1_RX_MUTE = 0;
	localparam int VR_AMP_MUTE = 3;
	localparam int C2_COMPAND = 7;
	localparam int C2_EMPH = 6;
	localparam int C2_PATTERN = 5;
	localparam int C2_KEY = 4;

	localparam logic [1:0] PWR_ALL_OFF = 2'b11;
	localparam logic [1:0] PWR_OSC_ONLY = 2'b01;
	localparam logic [1:0] PWR_RX = 2'b10;
	localparam logic [1:0] PWR_FULL = 2'b00;

	localparam logic [15:0] SYNC_BASE = 16'hC4D6;
	localparam logic [15:0] SYNC_PORTABLE = 16'h9336;
	localparam logic [4:0] GAIN4_ZERO = 5'h08;
	localparam logic [4:0] LEVEL_ZERO_DB = 5'h0C;
	localparam logic [4:0] LEVEL_STEP_DB = 5'h03;

	localparam logic [1:0] HREG_SER = 2'h0;
	localparam logic [1:0] HREG_RX = 2'h1;
	localparam logic [1:0] HREG_TX = 2'h2;
	localparam logic [1:0] HREG_STATUS = 2'h3;

	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_WR = 4'b0010,
		HS_RD = 4'b0100,
		HS_GUARD = 4'b1000
	} host_state_type;
endpackage : msk_modem_pkg

// ### modem_link_if.sv
// Purpose: Pins between host controller and modem device
// Assumes: Data line has a pull-up when nobody drives it
// Notes: Shared data line resolved here from both enables
interface modem_link_if;
	logic sclk;
	logic dir;
	logic host_host_serial_line_o;
	logic host_host_serial_line_oe;
	logic dev_host_serial_line_o;
	logic dev_host_serial_line_oe;
	logic host_serial_line;
	logic tx_bit_clock;
	logic tx_data;
	logic flag_pin;
	logic modulator_output;

	assign host_serial_line = host_host_serial_line_oe ? host_host_serial_line_o : (dev_host_serial_line_oe ? dev_host_serial_line_o : 1'b1);

	modport device (input sclk, input dir, input host_serial_line, input tx_data,
		output dev_host_serial_line_o, output dev_host_serial_line_oe, output tx_bit_clock, output flag_pin,
		output modulator_output);
	modport host (input host_serial_line, input tx_bit_clock, input flag_pin,
		output sclk, output dir, output host_host_serial_line_o, output host_host_serial_line_oe, output tx_data);
endinterface : modem_link_if

// ### msk_modem_device.sv
// Purpose: Modem device control logic: serial registers, MSK tx timing, frame hunt, rx byte
// Assumes: Demodulated bits arrive as rx_bit with a one-cycle rx_bit_valid
// Notes: Link pins are synchronised by two flops before use
//
// Our own choice: the plain strobed port.
module msk_modem_device import msk_modem_pkg::*; #(
	parameter int TX_HALF = TX_HALF_CYC, // Half period of the tx bit clock
	parameter int RX_BIT = RX_BIT_CYC // One rx bit period
) (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous, active high
	modem_link_if.device link, // Link pins
	input wire logic rx_bit, // Demodulated bit, 1 for low tone
	input wire logic rx_bit_valid, // One-cycle strobe per rx bit
	output logic osc_on, // Oscillator powered
	output logic rx_msk_on, // MSK receiver powered
	output logic voice_tx_on, // Voice path and MSK tx powered
	output logic scrambler_bypass, // Scrambler bypassed
	output logic tx_voice_mute, // Voice tx muted
	output logic rx_voice_mute, // Voice rx muted
	output logic receiver_amp_mute, // Receiver amplifier muted
	output logic emphasis_enable, // Emphasis on
	output logic compander_enable, // Compander on
	output logic invert_freq_sel, // Scrambler carrier select
	output logic test_mode, // Upper volume nibble not all ones
	output logic [4:0] gain_a_db, // Signed dB
	output logic [4:0] gain_b_half_db, // Signed half dB
	output logic [4:0] gain_c_half_db, // Signed half dB
	output logic [4:0] receive_level_db, // Signed dB
	output logic rx_data_node, // Internal rx data node
	output logic rx_clk_node // Internal rx clock node
);
	logic [1:0] sclk_s, dir_s, sd_s, txd_s;
	logic sclk_d, dir_d;
	logic sclk_rise, sclk_fall, dir_fall;
	logic [7:0] ctrl1_q, vol_rx_q, vol_tx_q, ctrl2_q;
	logic [9:0] wr_sr_q;
	logic [3:0] wr_cnt_q;
	logic wr_ok;
	logic [15:0] sync_sr_q;
	logic [15:0] pattern;
	logic hunting, frame_hit, rx_active_q;
	logic [7:0] byte_sr_q, rd_sr_q;
	logic [2:0] bit_cnt_q, rd_cnt_q;
	logic byte_done;
	logic ready_n_q, fd_n_q;
	logic [15:0] fd_cnt_q, tx_cnt_q;
	logic msk_tx, tx_bit_clock_q, mod_q;
	logic dev_o_q, dev_oe_q, flag_q;

	function automatic logic [4:0] code_minus_eight(input logic [3:0] c);
		return {1'b0, c} - GAIN4_ZERO;
	endfunction : code_minus_eight

	always_ff @(posedge clk) begin
		if (reset) begin
			sclk_s <= 2'h0;
			dir_s <= 2'h0;
			sd_s <= 2'h3;
			txd_s <= 2'h0;
			sclk_d <= 1'b0;
			dir_d <= 1'b0;
		end else begin
			sclk_s <= {sclk_s[0], link.sclk};
			dir_s <= {dir_s[0], link.dir};
			sd_s <= {sd_s[0], link.host_serial_line};
			txd_s <= {txd_s[0], link.tx_data};
			sclk_d <= sclk_s[1];
			dir_d <= dir_s[1];
		end
	end
	assign sclk_rise = sclk_s[1] & ~sclk_d;
	assign sclk_fall = ~sclk_s[1] & sclk_d;
	assign dir_fall = ~dir_s[1] & dir_d;

	// Serial write frame: dir high, ten bits sampled on sclk rising
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_sr_q <= 10'h000;
			wr_cnt_q <= 4'h0;
		end else if (!dir_s[1]) begin
			wr_cnt_q <= 4'h0;
		end else if (sclk_rise) begin
			wr_sr_q <= {wr_sr_q[8:0], sd_s[1]};
			if (wr_cnt_q != 4'hF)
				wr_cnt_q <= wr_cnt_q + 4'h1;
		end
	end
	// Short or long frames are dropped rather than half applied
	assign wr_ok = dir_fall && (wr_cnt_q == 4'(WR_BITS));

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl1_q <= CTRL1_RST;
		end else begin
			if (wr_ok && wr_sr_q[9:8] == ADDR_CTRL1)
				ctrl1_q <= wr_sr_q[7:0];
			if (frame_hit)
				ctrl1_q[C1_HUNT] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			vol_rx_q <= VOL_RX_RST;
			vol_tx_q <= VOL_TX_RST;
			ctrl2_q <= CTRL2_RST;
		end else if (wr_ok) begin
			if (wr_sr_q[9:8] == ADDR_VOL_RX)
				vol_rx_q <= wr_sr_q[7:0];
			if (wr_sr_q[9:8] == ADDR_VOL_TX)
				vol_tx_q <= wr_sr_q[7:0];
			if (wr_sr_q[9:8] == ADDR_CTRL2)
				ctrl2_q <= wr_sr_q[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			osc_on <= 1'b1;
			rx_msk_on <= 1'b1;
			voice_tx_on <= 1'b0;
		end else begin
			osc_on <= {ctrl1_q[C1_PWR_HI], ctrl1_q[C1_PWR_LO]} != PWR_ALL_OFF;
			rx_msk_on <= !ctrl1_q[C1_PWR_LO];
			voice_tx_on <= {ctrl1_q[C1_PWR_HI], ctrl1_q[C1_PWR_LO]} == PWR_FULL;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			scrambler_bypass <= 1'b1;
			tx_voice_mute <= 1'b0;
			rx_voice_mute <= 1'b0;
			receiver_amp_mute <= 1'b0;
			emphasis_enable <= 1'b1;
			compander_enable <= 1'b1;
			invert_freq_sel <= 1'b1;
			test_mode <= 1'b0;
			gain_a_db <= 5'h00;
			gain_b_half_db <= 5'h00;
			gain_c_half_db <= 5'h00;
			receive_level_db <= 5'h00;
		end else begin
			scrambler_bypass <= ctrl1_q[C1_SCR_BYP];
			tx_voice_mute <= ctrl1_q[C1_TX_MUTE] | ~ctrl1_q[C1_TX_DIS];
			rx_voice_mute <= ctrl1_q[C1_RX_MUTE];
			receiver_amp_mute <= vol_rx_q[VR_AMP_MUTE];
			emphasis_enable <= ctrl2_q[C2_EMPH];
			compander_enable <= ctrl2_q[C2_COMPAND];
			invert_freq_sel <= ctrl2_q[C2_KEY];
			test_mode <= vol_rx_q[7:4] != VOL_RX_FIXED;
			gain_a_db <= code_minus_eight(vol_tx_q[3:0]);
			gain_b_half_db <= code_minus_eight(vol_tx_q[7:4]);
			gain_c_half_db <= code_minus_eight(ctrl2_q[3:0]);
			receive_level_db <= 5'({2'h0, vol_rx_q[2:0]} * LEVEL_STEP_DB) - LEVEL_ZERO_DB;
		end
	end

	// Frame hunt
	assign pattern = ctrl2_q[C2_PATTERN] ? SYNC_BASE : SYNC_PORTABLE;
	assign hunting = !ctrl1_q[C1_HUNT] && rx_msk_on && !rx_active_q;
	assign frame_hit = hunting && rx_bit_valid && ({sync_sr_q[14:0], rx_bit} == pattern);

	always_ff @(posedge clk) begin
		if (reset) begin
			sync_sr_q <= 16'h0000;
		end else if (frame_hit || !hunting) begin
			sync_sr_q <= 16'h0000;
		end else if (rx_bit_valid) begin
			sync_sr_q <= {sync_sr_q[14:0], rx_bit};
		end
	end

	// Active from the hit until the host rewrites hunt to zero
	always_ff @(posedge clk) begin
		if (reset)
			rx_active_q <= 1'b0;
		else if (frame_hit)
			rx_active_q <= 1'b1;
		else if (wr_ok && wr_sr_q[9:8] == ADDR_CTRL1 && !wr_sr_q[C1_HUNT])
			rx_active_q <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_data_node <= 1'b1;
			rx_clk_node <= 1'b1;
		end else if (rx_active_q) begin
			rx_data_node <= rx_valid_bit(rx_bit, rx_bit_valid, rx_data_node);
			rx_clk_node <= rx_bit_valid;
		end else begin
			rx_data_node <= 1'b1;
			rx_clk_node <= 1'b1;
		end
	end

	function automatic logic rx_valid_bit(input logic b, input logic v, input logic old);
		return v ? b : old;
	endfunction : rx_valid_bit

	always_ff @(posedge clk) begin
		if (reset) begin
			fd_n_q <= 1'b1;
			fd_cnt_q <= 16'h0000;
		end else if (frame_hit) begin
			fd_n_q <= 1'b0;
			fd_cnt_q <= 16'(RX_BIT - 1);
		end else if (fd_cnt_q != 16'h0000) begin
			fd_cnt_q <= fd_cnt_q - 16'h0001;
		end else begin
			fd_n_q <= 1'b1;
		end
	end

	// Byte assembly, first bit ends in bit 7
	assign byte_done = rx_active_q && rx_bit_valid && (bit_cnt_q == 3'h7);
	always_ff @(posedge clk) begin
		if (reset) begin
			byte_sr_q <= 8'h00;
			bit_cnt_q <= 3'h0;
		end else if (!rx_active_q) begin
			bit_cnt_q <= 3'h0;
		end else if (rx_bit_valid) begin
			byte_sr_q <= {byte_sr_q[6:0], rx_bit};
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// Read side: no address, shifted out while dir low
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_sr_q <= 8'h00;
			rd_cnt_q <= 3'h0;
			ready_n_q <= 1'b1;
		end else if (byte_done) begin
			rd_sr_q <= {byte_sr_q[6:0], rx_bit};
			rd_cnt_q <= 3'h0;
			ready_n_q <= 1'b0;
		end else if (!dir_s[1]) begin
			if (sclk_rise) begin
				rd_cnt_q <= rd_cnt_q + 3'h1;
				if (rd_cnt_q == 3'(RD_BITS - 1))
					ready_n_q <= 1'b1;
			end
			if (sclk_fall)
				rd_sr_q <= {rd_sr_q[6:0], 1'b0};
		end
	end

	// Tx: clock starts low so the first rising comes half a bit later
	assign msk_tx = !ctrl1_q[C1_TX_DIS] && ctrl1_q[C1_TX_MUTE] && voice_tx_on;
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_cnt_q <= 16'h0000;
			tx_bit_clock_q <= 1'b0;
			mod_q <= 1'b0;
		end else if (!msk_tx) begin
			tx_cnt_q <= 16'h0000;
			tx_bit_clock_q <= 1'b0;
		end else if (tx_cnt_q == 16'(TX_HALF - 1)) begin
			tx_cnt_q <= 16'h0000;
			tx_bit_clock_q <= ~tx_bit_clock_q;
			if (!tx_bit_clock_q)
				mod_q <= txd_s[1];
		end else begin
			tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dev_o_q <= 1'b1;
			dev_oe_q <= 1'b0;
			flag_q <= 1'b1;
		end else begin
			dev_o_q <= rd_sr_q[7];
			dev_oe_q <= !dir_s[1];
			flag_q <= ctrl1_q[C1_FLAG_SEL] ? ready_n_q : fd_n_q;
		end
	end

	assign link.dev_host_serial_line_o = dev_o_q;
	assign link.dev_host_serial_line_oe = dev_oe_q;
	assign link.tx_bit_clock = tx_bit_clock_q;
	assign link.modulator_output = mod_q;
	assign link.flag_pin = flag_q;
endmodule : msk_modem_device

// ### msk_modem_host.sv
// Purpose: Host controller end: serial writes, byte reads, MSK tx bit feed
// Assumes: Software polls status before issuing a new command
// Notes: Commands arriving while busy are dropped
module msk_modem_host import msk_modem_pkg::*; #(
	parameter int GUARD = VOICE_GUARD_CYC, // Wait after tx disable
	parameter int HALF = SCLK_HALF_CYC // Serial clock half period
) (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous, active high
	modem_link_if.host link, // Link pins
	input wire logic [1:0] addr, // Host register address
	input wire logic [15:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [15:0] rdata // Read data, cycle after rd
);
	host_state_type state_q;
	logic [1:0] sd_s, tx_bit_clock_s, flag_s;
	logic tx_bit_clock_d;
	logic [9:0] sr_q, pend_q;
	logic [4:0] tick_n_q;
	logic [7:0] half_q, rx_byte_q, tx_sr_q;
	logic [3:0] tx_left_q;
	logic [15:0] guard_q;
	logic sclk_q, dir_q, oe_q, tick, idle, cmd_ser;
	logic [9:0] ser_word;

	always_ff @(posedge clk) begin
		if (reset) begin
			sd_s <= 2'h3;
			tx_bit_clock_s <= 2'h0;
			flag_s <= 2'h3;
			tx_bit_clock_d <= 1'b0;
		end else begin
			sd_s <= {sd_s[0], link.host_serial_line};
			tx_bit_clock_s <= {tx_bit_clock_s[0], link.tx_bit_clock};
			flag_s <= {flag_s[0], link.flag_pin};
			tx_bit_clock_d <= tx_bit_clock_s[1];
		end
	end

	assign tick = (half_q == 8'(HALF - 1));
	always_ff @(posedge clk) begin
		if (reset || state_q == HS_IDLE || tick)
			half_q <= 8'h00;
		else
			half_q <= half_q + 8'h01;
	end

	assign idle = (state_q == HS_IDLE);
	assign cmd_ser = wr && addr == HREG_SER && idle;
	// Volume nibble forced to ones so test mode is never entered
	assign ser_word = (wdata[9:8] == ADDR_VOL_RX) ? {wdata[9:8], VOL_RX_FIXED, wdata[3:0]}
		: wdata[9:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			guard_q <= 16'h0000;
		// Shifter is empty by the last tick, so the pending word names the target
		end else if (state_q == HS_WR && tick && tick_n_q == 5'h01 && pend_q[9:8] == ADDR_CTRL1
			&& pend_q[C1_TX_DIS]) begin
			guard_q <= 16'(GUARD);
		end else if (guard_q != 16'h0000) begin
			guard_q <= guard_q - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= HS_IDLE;
			sclk_q <= 1'b0;
			dir_q <= 1'b0;
			oe_q <= 1'b0;
			sr_q <= 10'h000;
			pend_q <= 10'h000;
			tick_n_q <= 5'h00;
			rx_byte_q <= 8'h00;
		end else begin
			unique case (state_q)
				HS_IDLE: begin
					if (cmd_ser) begin
						pend_q <= ser_word;
						state_q <= HS_GUARD;
					end else if (wr && addr == HREG_RX && !flag_s[1]) begin
						tick_n_q <= 5'(2 * RD_BITS);
						state_q <= HS_RD;
					end
				end
				HS_GUARD: begin
					// Unmuting voice waits until the guard started by a tx disable write has run out
					if (!(pend_q[9:8] == ADDR_CTRL1 && !pend_q[C1_TX_MUTE] && guard_q != 16'h0000)) begin
						sr_q <= pend_q;
						dir_q <= 1'b1;
						oe_q <= 1'b1;
						tick_n_q <= 5'(2 * WR_BITS + 1);
						state_q <= HS_WR;
					end
				end
				HS_WR: begin
					if (tick) begin
						tick_n_q <= tick_n_q - 5'h01;
						if (tick_n_q == 5'h01) begin
							dir_q <= 1'b0;
							oe_q <= 1'b0;
							state_q <= HS_IDLE;
						end else if (!sclk_q) begin
							sclk_q <= 1'b1;
						end else begin
							sclk_q <= 1'b0;
							sr_q <= {sr_q[8:0], 1'b0};
						end
					end
				end
				HS_RD: begin
					if (tick) begin
						tick_n_q <= tick_n_q - 5'h01;
						sclk_q <= ~sclk_q;
						if (!sclk_q)
							rx_byte_q <= {rx_byte_q[6:0], sd_s[1]};
						if (tick_n_q == 5'h01)
							state_q <= HS_IDLE;
					end
				end
			endcase
		end
	end

	// Tx bits: next bit presented after each falling bit clock edge
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_sr_q <= 8'h00;
			tx_left_q <= 4'h0;
		end else if (wr && addr == HREG_TX && tx_left_q == 4'h0) begin
			tx_sr_q <= wdata[7:0];
			tx_left_q <= 4'h8;
		end else if (!tx_bit_clock_s[1] && tx_bit_clock_d && tx_left_q != 4'h0) begin
			tx_sr_q <= {tx_sr_q[6:0], 1'b0};
			tx_left_q <= tx_left_q - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			rdata <= 16'h0000;
		else if (rd && addr == HREG_RX)
			rdata <= {8'h00, rx_byte_q};
		else if (rd && addr == HREG_STATUS)
			rdata <= {12'h000, guard_q != 16'h0000, tx_left_q != 4'h0, flag_s[1], !idle};
		else
			rdata <= 16'h0000;
	end

	assign link.sclk = sclk_q;
	assign link.dir = dir_q;
	assign link.host_host_serial_line_o = sr_q[9];
	assign link.host_host_serial_line_oe = oe_q;
	assign link.tx_data = tx_sr_q[7];
endmodule : msk_modem_host

// ### msk_modem_link_sva.sv
// Purpose: Link-level assertions between the host and device ends
// Assumes: One clock domain; sees the interface signals only
// Notes: TX_HALF must match the device instance
module msk_modem_link_sva import msk_modem_pkg::*; #(
	parameter int TX_HALF = TX_HALF_CYC // Tx bit clock half period
) (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous, active high
	input wire logic sclk, // Serial clock
	input wire logic dir, // Frame direction
	input wire logic host_host_serial_line_oe, // Host drives data line
	input wire logic dev_host_serial_line_oe, // Device drives data line
	input wire logic tx_bit_clock, // Tx bit clock
	input wire logic flag_pin, // Ready or frame flag
	input wire logic modulator_output // Modulated bit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic sclk_q, dir_q, tck_q, tck2_q;
	logic [15:0] hi_q, lo_q;
	logic [3:0] rd_q, wr_q;
	wire logic sclk_up = sclk && !sclk_q;
	always_ff @(posedge clk) begin
		sclk_q <= reset ? 1'b0 : sclk;
		dir_q <= reset ? 1'b0 : dir;
		tck_q <= reset ? 1'b0 : tx_bit_clock;
		tck2_q <= reset ? 1'b0 : tck_q;
	end
	// Low count saturates, so a long idle never wraps into a short phase
	always_ff @(posedge clk) begin
		hi_q <= (reset || !tx_bit_clock) ? 16'h0000 : hi_q + 16'h0001;
		lo_q <= (reset || tx_bit_clock) ? 16'hFFFF : lo_q + {15'h0000, lo_q != 16'hFFFF};
		if (reset || tx_bit_clock) begin
			lo_q <= reset ? 16'hFFFF : 16'h0000;
		end
	end
	always_ff @(posedge clk) begin
		if (reset || dir) begin
			rd_q <= 4'h0;
		end else if (sclk_up) begin
			rd_q <= (rd_q == 4'h7) ? 4'h0 : rd_q + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset || (dir && !dir_q)) begin
			wr_q <= 4'h0;
		end else if (dir && sclk_up) begin
			wr_q <= wr_q + 4'h1;
		end
	end
	reset_idle_a: assert property ($fell(reset) |-> flag_pin && !tx_bit_clock && !dev_host_serial_line_oe)
		else $error("link outputs not idle after reset");
	tx_high_a: assert property (hi_q <= TX_HALF)
		else $error("tx bit clock high too long");
	tx_low_a: assert property (tx_bit_clock && !tck_q |-> lo_q >= TX_HALF)
		else $error("tx bit clock low too short");
	mod_edge_a: assert property ($changed(modulator_output) |-> (tx_bit_clock && !tck_q) || (tck_q && !tck2_q))
		else $error("modulator output changed away from a tx clock rise");
	dev_release_a: assert property (dir [*4] |-> !dev_host_serial_line_oe)
		else $error("device drives data line in a write frame");
	host_own_a: assert property (host_host_serial_line_oe |-> dir)
		else $error("host drives data line outside a write frame");
	read_start_a: assert property (sclk_up && !dir && rd_q == 4'h0 |-> !flag_pin)
		else $error("read clocks started without ready low");
	ready_back_a: assert property (sclk_up && !dir && rd_q == 4'h7 |-> ##[1:8] flag_pin)
		else $error("ready flag not high after eight read clocks");
	write_len_a: assert property (!dir && dir_q |-> wr_q == WR_BITS)
		else $error("write frame without ten bits");
	cover property (tx_bit_clock && !tck_q);
	cover property (sclk_up && !dir && rd_q == 4'h7);
	cover property (!dir && dir_q);
endmodule : msk_modem_link_sva

// ### msk_modem_control_interface_tb.sv
// Purpose: Host and device ends joined over the link, driven from the host port and the device rx_bit input
// Assumes: Shortened tx, rx and guard counts
// Notes: Reads and tx bits are checked from expectation queues
module msk_modem_control_interface_tb import msk_modem_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TXH = 8;
	localparam int RXB = 16;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic chk = 1'b0;
	logic rd_q = 1'b0;
	logic [1:0] tcd = 2'h0;
	logic rx_bit = 1'b0;
	logic rx_bit_valid = 1'b0;
	logic [15:0] rdata;
	logic osc_on, rx_msk_on, voice_tx_on, amp_mute, test_mode, rx_dn, rx_cn;
	logic scr, rxm, emp, cmp, inv, tx_mute;
	logic [4:0] ga, gb, gc, gl;
	logic [15:0] rq[$];
	logic tq[$];
	int err_count = 0;
	int n_checks = 0;
	int lo_cnt = 0;
	int seed = 50385;
	modem_link_if link ();
	always #25 clk = ~clk;
	msk_modem_host #(.GUARD(200), .HALF(10)) msk_modem_host_i (.clk(clk), .reset(reset),
		.link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	msk_modem_device #(.TX_HALF(TXH), .RX_BIT(RXB)) msk_modem_device_i (.clk(clk), .reset(reset),
		.link(link), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .osc_on(osc_on),
		.rx_msk_on(rx_msk_on), .voice_tx_on(voice_tx_on), .scrambler_bypass(scr),
		.tx_voice_mute(tx_mute), .rx_voice_mute(rxm), .receiver_amp_mute(amp_mute),
		.emphasis_enable(emp), .compander_enable(cmp), .invert_freq_sel(inv),
		.test_mode(test_mode), .gain_a_db(ga), .gain_b_half_db(gb),
		.gain_c_half_db(gc), .receive_level_db(gl), .rx_data_node(rx_dn), .rx_clk_node(rx_cn));
	msk_modem_link_sva #(.TX_HALF(TXH)) msk_modem_link_sva_i (.clk(clk), .reset(reset),
		.sclk(link.sclk), .dir(link.dir), .host_host_serial_line_oe(link.host_host_serial_line_oe),
		.dev_host_serial_line_oe(link.dev_host_serial_line_oe), .tx_bit_clock(link.tx_bit_clock),
		.flag_pin(link.flag_pin), .modulator_output(link.modulator_output));
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_up(input string what);
		err_count++;
		$display("MISMATCH %s expected done seen timeout", what);
		print_verdict();
	endtask : give_up
	task automatic cmd(input logic [1:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : cmd
	task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
		rq.push_back(e);
		addr <= a;
		rd <= 1'b1;
		chk <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		chk <= 1'b0;
	endtask : rd_chk
	// Status polls are unchecked reads, so they stay off the queue
	task automatic wait_st(input logic [15:0] m, input logic [15:0] v);
		logic [15:0] s;
		s = 16'hFFFF;
		for (int n = 0; (s & m) !== v; n++) begin
			if (n == 3000) give_up("status");
			addr <= HREG_STATUS;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(negedge clk);
			s = rdata;
			@(posedge clk);
		end
	endtask : wait_st
	task automatic ser(input logic [1:0] a, input logic [7:0] d);
		cmd(HREG_SER, {6'h00, a, d});
		wait_st(16'h0009, 16'h0000);
		repeat (8) @(posedge clk);
	endtask : ser
	task automatic rx_send(input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			rx_bit <= v[i];
			rx_bit_valid <= 1'b1;
			@(posedge clk);
			rx_bit_valid <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : rx_send
	always @(posedge clk) begin
		rd_q <= rd & chk;
		tcd <= {tcd[0], link.tx_bit_clock};
		lo_cnt <= lo_cnt + ((link.flag_pin === 1'b0) ? 1 : 0);
		if (rd_q && rq.size() > 0) check("rdata", rdata, rq.pop_front());
		if (tcd == 2'b01 && tq.size() > 0) check("mod", {15'h0, link.modulator_output}, {15'h0, tq.pop_front()});
	end
	initial begin
		logic [7:0] b;
		logic [3:0] ca, cb, cc, cx;
		logic [2:0] cl;
		logic [15:0] pat;
		int lo0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check("gains", {1'b0, ga, gb, gc}, 16'h0000);
		check("level", {11'h0, gl}, 16'h0000);
		check("amp_mute", {15'h0, amp_mute}, 16'h0000);
		check("opts", {10'h0, tx_mute, scr, rxm, emp, cmp, inv}, 16'h0017);
		check("flag", {15'h0, link.flag_pin}, 16'h0001);
		rd_chk(HREG_SER, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			{cx, ca, cb, cc, cl} = 19'($random(seed));
			ser(ADDR_VOL_TX, {cb, ca});
			ser(ADDR_VOL_RX, {4'h0, ca[0], cl});
			ser(ADDR_CTRL2, {cx, cc});
			check("gain_a", {11'h0, ga}, {11'h0, ({1'b0, ca} - 5'h08)});
			check("gain_b", {11'h0, gb}, {11'h0, ({1'b0, cb} - 5'h08)});
			check("gain_c", {11'h0, gc}, {11'h0, ({1'b0, cc} - 5'h08)});
			check("level", {11'h0, gl}, {11'h0, ({2'b00, cl} * 5'h03 - 5'h0C)});
			check("amp_test", {14'h0, amp_mute, test_mode}, {14'h0, ca[0], 1'b0});
			check("opts", {11'h0, scr, rxm, emp, cmp, inv}, {11'h0, 2'b10, cx[2], cx[3], cx[0]});
		end
		for (int p = 3; p >= 0; p--) begin
			ser(ADDR_CTRL1, {1'b1, 2'(p), 5'h1C});
			check("power", {13'h0, osc_on, rx_msk_on, voice_tx_on}, {13'h0, p != 3, p[0] == 1'b0, p == 0});
		end
		for (int s = 1; s >= 0; s--) begin
			pat = s ? SYNC_BASE : SYNC_PORTABLE;
			ser(ADDR_CTRL2, {2'b11, 1'(s), 5'h18});
			ser(ADDR_CTRL1, CTRL1_RST);
			rx_send(s ? SYNC_PORTABLE : SYNC_BASE, 16);
			repeat (40) @(posedge clk);
			check("nodes", {14'h0, rx_dn, rx_cn}, 16'h0003);
			check("flag", {15'h0, link.flag_pin}, 16'h0001);
			b = 8'($random(seed));
			rx_send(pat, 16);
			check("hit", {15'h0, rx_cn}, 16'h0000);
			rx_send({8'h00, b}, 8);
			wait_st(16'h0002, 16'h0000);
			cmd(HREG_RX, 16'h0000);
			wait_st(16'h0009, 16'h0000);
			rd_chk(HREG_RX, {8'h00, b});
			repeat (4) @(posedge clk);
			check("flag", {15'h0, link.flag_pin}, 16'h0001);
			rx_send(pat, 16);
			rx_send({8'h00, ~b}, 8);
			repeat (40) @(posedge clk);
			// No new search while a frame is open: the repeated pattern is just data
			check("flag", {15'h0, link.flag_pin}, 16'h0000);
			cmd(HREG_RX, 16'h0000);
			wait_st(16'h0009, 16'h0000);
			rd_chk(HREG_RX, {8'h00, ~b});
		end
		ser(ADDR_CTRL1, 8'h4C);
		@(negedge clk);
		lo0 = lo_cnt;
		@(posedge clk);
		rx_send(SYNC_PORTABLE, 16);
		repeat (60) @(posedge clk);
		@(negedge clk);
		check("pulse", 16'(lo_cnt - lo0), 16'(RXB));
		@(posedge clk);
		b = 8'($random(seed));
		for (int i = 7; i >= 0; i--) tq.push_back(b[i]);
		cmd(HREG_TX, {8'h00, b});
		@(posedge clk);
		ser(ADDR_CTRL1, 8'h9A);
		for (int n = 0; tq.size() > 0; n++) begin
			if (n == 3000) give_up("tx bits");
			@(posedge clk);
		end
		check("tx_mute", {15'h0, tx_mute}, 16'h0001);
		cmd(HREG_SER, {6'h00, ADDR_CTRL1, 8'h9E});
		wait_st(16'h0001, 16'h0000);
		repeat (8) @(posedge clk);
		check("tx_clock", {15'h0, link.tx_bit_clock}, 16'h0000);
		// Unmute asked for at once; the host must sit on it until the guard ends
		cmd(HREG_SER, {6'h00, ADDR_CTRL1, 8'h9C});
		repeat (280) @(posedge clk);
		check("held", {15'h0, tx_mute}, 16'h0001);
		wait_st(16'h0009, 16'h0000);
		repeat (8) @(posedge clk);
		check("voice", {15'h0, tx_mute}, 16'h0000);
		print_verdict();
	end
endmodule : msk_modem_control_interface_tb
